// ### logic/ext_irq_unit.sv
/*
  External pin interrupt unit: three pin lines with sense control, flags,
  enables and a fixed-priority vector request to the cpu, plus an event
  status/mask pair, a wake request and an AHB-Lite register slave.
  Assumes pins synchronous to hclk, a single AHB master, and that the cpu
  pulses vector_ack when it enters the routine of the presented vector.
*/
`timescale 1ns/1ps
`default_nettype none
// Contract
// [R1] line zero requests only with global enable and its own enable set
// [R2] line zero is sampled before edge detection; longer pulses are caught
// [R3] driver holds line zero low until the current instruction completes
// [R4] line zero sense: 00 low, 01 any change, 10 falling, 11 rising
// [R5] line two edge select zero means falling edge
// [R6] line two edge select one means rising edge; no level option
// [R7] line two edges are caught without the i/o clock; 50 ns pulses suffice
// [R8] software disables line two, changes sense, clears flag, re-enables
// [R9] enable bits: 7 line one, 6 line zero, 5 line two, with global enable
// [R10] pin activity triggers even when the pin is driven as output
// [R11] each line has its own vector
// [R12] trigger events set flags: 7 line one, 6 line zero, 5 line two
// [R13] flag plus enable plus global enable requests the line's vector
// [R14] flag clears on vector entry or on writing one; zero does nothing
// [R15] flag of a level-sensed line zero or one is held at zero
// [R16] sleep with line two disabled blocks its input, which may set its flag
// [R17] line zero/one edges need the i/o clock; low levels do not
// [R18] level wake-up needs the low level on two slow sampling ticks
// [R19] pending requests are presented line zero, then one, then two
module ext_irq_unit
  import ext_irq_pkg::*;
#(
  parameter int unsigned WAKE_TICK_CYC = WDT_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ext_irq_line_zero,
  input wire logic ext_irq_line_one,
  input wire logic ext_irq_line_two,
  input wire logic io_clk_run,
  input wire logic sleep_deep,
  input wire logic vector_ack,
  output logic irq_req,
  output logic [1:0] irq_vector,
  output logic irq,
  output logic wake_req
);

  if (T_INT_CYC < 1) begin : g_chk
    $error("ext_irq_unit: clock too slow for the line two pulse width");
  end

  function automatic logic [3:0] reg_index(input logic [31:0] a);
    logic [3:0] idx;
    idx = IDX_NONE;
    if (a == OFS_MCU_CTRL) idx = IDX_MCU_CTRL;
    else if (a == OFS_MCU_CTRL_STATUS) idx = IDX_MCU_CTRL_STATUS;
    else if (a == OFS_EXT_IRQ_ENABLE) idx = IDX_EXT_IRQ_ENABLE;
    else if (a == OFS_EXT_IRQ_FLAGS) idx = IDX_EXT_IRQ_FLAGS;
    else if (a == OFS_CPU_STATUS_WORD) idx = IDX_CPU_STATUS_WORD;
    else if (a == OFS_EVT_STATUS) idx = IDX_EVT_STATUS;
    else if (a == OFS_EVT_MASK) idx = IDX_EVT_MASK;
    else if (a == OFS_PIN_STATE) idx = IDX_PIN_STATE;
    return idx;
  endfunction : reg_index

  // registers
  logic [7:0] mcu_ctrl_r;
  logic line2_edge_select_r;
  logic [7:0] ext_irq_enable_r;
  logic [7:0] ext_irq_flags_r;
  logic [7:0] ext_irq_flags_nxt;
  logic global_en_r;
  logic [7:0] evt_status_r;
  logic [7:0] evt_status_nxt;
  logic [7:0] evt_mask_r;

  // bus state
  bus_state_e bus_st_r;
  bus_state_e bus_st_nxt;
  logic wr_pend_r;
  logic [31:0] wr_addr_r;
  logic [31:0] rd_addr_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic hresp_r;

  // outputs
  logic irq_req_r;
  logic [1:0] irq_vector_r;
  logic irq_r;
  logic wake_req_r;

  // line signals
  logic [1:0] line0_sense;
  logic [1:0] line1_sense;
  logic line0_sense_hi;
  logic line0_sense_lo;
  logic line0_lvl_mode;
  logic line1_lvl_mode;
  logic line2_in;
  logic trig0;
  logic trig1;
  logic trig2;
  logic lvl0;
  logic lvl1;
  logic lvl2;
  logic low0;
  logic low1;
  logic en0;
  logic en1;
  logic en2;
  logic req0;
  logic req1;
  logic req2;
  logic [1:0] vec_nxt;
  logic wake_lvl;
  logic [1:0] wake_low;

  // bus decode
  logic addr_phase;
  logic rd_start;
  logic wr_start;
  logic [3:0] wr_idx;
  logic [3:0] rd_idx;
  logic [7:0] wdat;
  logic wr_ctrl;
  logic wr_ctrl_status;
  logic wr_enable;
  logic wr_flags;
  logic wr_status_word;
  logic wr_mask;
  logic rd_now;
  logic [7:0] rd_byte;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic [7:0] flag_hold;
  logic [7:0] ack_clr;
  logic [7:0] evt_set;
  logic [7:0] evt_clr;
  logic [7:0] pin_state;

  // ---------------- AHB-Lite slave ----------------
  assign addr_phase = hsel & hready & htrans[1];
  assign rd_start = addr_phase & ~hwrite;
  assign wr_start = addr_phase & hwrite & (hsize == HSIZE_WORD);
  assign wr_idx = reg_index(wr_addr_r);
  assign rd_idx = reg_index(rd_addr_r);
  assign wdat = hwdata[7:0];
  assign wr_ctrl = wr_pend_r & (wr_idx == IDX_MCU_CTRL);
  assign wr_ctrl_status = wr_pend_r & (wr_idx == IDX_MCU_CTRL_STATUS);
  assign wr_enable = wr_pend_r & (wr_idx == IDX_EXT_IRQ_ENABLE);
  assign wr_flags = wr_pend_r & (wr_idx == IDX_EXT_IRQ_FLAGS);
  assign wr_status_word = wr_pend_r & (wr_idx == IDX_CPU_STATUS_WORD);
  assign wr_mask = wr_pend_r & (wr_idx == IDX_EVT_MASK);
  assign rd_now = (bus_st_r == BUS_RDWAIT);

  // reads take one wait cycle so a write just before is already visible
  always_comb begin
    bus_st_nxt = bus_st_r;
    case (bus_st_r)
      BUS_IDLE: begin
        if (rd_start) bus_st_nxt = BUS_RDWAIT;
      end
      BUS_RDWAIT: begin
        bus_st_nxt = BUS_IDLE;
      end
      default: begin
        bus_st_nxt = BUS_IDLE;
      end
    endcase
  end

  assign pin_state = {lvl1, lvl0, lvl2, 3'h0, irq_vector_r};

  assign rd_byte =
    (rd_idx == IDX_MCU_CTRL) ? mcu_ctrl_r :
    (rd_idx == IDX_MCU_CTRL_STATUS) ?
      (8'h00 | (8'(line2_edge_select_r) << BIT_LINE2_EDGE)) :
    (rd_idx == IDX_EXT_IRQ_ENABLE) ? ext_irq_enable_r :
    (rd_idx == IDX_EXT_IRQ_FLAGS) ? ext_irq_flags_r :
    (rd_idx == IDX_CPU_STATUS_WORD) ?
      (8'h00 | (8'(global_en_r) << BIT_GLOBAL_EN)) :
    (rd_idx == IDX_EVT_STATUS) ? evt_status_r :
    (rd_idx == IDX_EVT_MASK) ? evt_mask_r :
    (rd_idx == IDX_PIN_STATE) ? pin_state : 8'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_st_r <= BUS_IDLE;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 32'h0000_0000;
      rd_addr_r <= 32'h0000_0000;
      hrdata_r <= 32'h0000_0000;
      hreadyout_r <= 1'b1;
      hresp_r <= HRESP_OKAY;
    end else begin
      bus_st_r <= bus_st_nxt;
      wr_pend_r <= wr_start;
      hreadyout_r <= (bus_st_nxt != BUS_RDWAIT);
      hresp_r <= HRESP_OKAY;
      if (wr_start) wr_addr_r <= haddr;
      if (rd_start) rd_addr_r <= haddr;
      if (rd_now) hrdata_r <= {24'h00_0000, rd_byte};
    end
  end

  // ---------------- control registers ----------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mcu_ctrl_r <= RST_BYTE;
      line2_edge_select_r <= 1'b0;
      ext_irq_enable_r <= RST_BYTE;
      global_en_r <= 1'b0;
      evt_mask_r <= RST_BYTE;
    end else begin
      if (wr_ctrl) mcu_ctrl_r <= wdat; // R4
      if (wr_ctrl_status) line2_edge_select_r <= wdat[BIT_LINE2_EDGE]; // R5 R6
      if (wr_enable) ext_irq_enable_r <= wdat & LINE_MASK; // R9
      if (wr_status_word) global_en_r <= wdat[BIT_GLOBAL_EN];
      if (wr_mask) evt_mask_r <= wdat & LINE_MASK;
    end
  end

  // ---------------- line sensing ----------------
  assign line0_sense_hi = mcu_ctrl_r[POS_LINE0_SENSE + 1];
  assign line0_sense_lo = mcu_ctrl_r[POS_LINE0_SENSE];
  assign line0_sense = {line0_sense_hi, line0_sense_lo}; // R4
  assign line1_sense = mcu_ctrl_r[POS_LINE1_SENSE +: 2];
  assign line0_lvl_mode = (line0_sense == SENSE_LOW);
  assign line1_lvl_mode = (line1_sense == SENSE_LOW);
  assign en0 = ext_irq_enable_r[BIT_LINE0];
  assign en1 = ext_irq_enable_r[BIT_LINE1];
  assign en2 = ext_irq_enable_r[BIT_LINE2];

  // pins are read whatever their output direction
  line_sense u_line0 ( // R2 R10
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(ext_irq_line_zero),
    .sense(line0_sense),
    .clk_run(io_clk_run), // R17
    .trig(trig0),
    .level(lvl0)
  );

  line_sense u_line1 (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(ext_irq_line_one),
    .sense(line1_sense),
    .clk_run(io_clk_run), // R17
    .trig(trig1),
    .level(lvl1)
  );

  // deep sleep with line two disabled turns its input buffer off
  assign line2_in = ext_irq_line_two & ~(sleep_deep & ~en2); // R16

  // line two runs on the free clock, so the i/o clock gate does not apply
  line_sense u_line2 ( // R7
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(line2_in),
    .sense({1'b1, line2_edge_select_r}), // R5 R6
    .clk_run(1'b1),
    .trig(trig2),
    .level(lvl2)
  );

  // low levels act straight from the pin, without the i/o clock
  assign low0 = ~ext_irq_line_zero; // R17
  assign low1 = ~ext_irq_line_one;

  // ---------------- flags ----------------
  always_comb begin
    flag_set = 8'h00;
    flag_set[BIT_LINE0] = trig0 & ~line0_lvl_mode; // R12
    flag_set[BIT_LINE1] = trig1 & ~line1_lvl_mode; // R12
    flag_set[BIT_LINE2] = trig2; // R12
    flag_hold = 8'h00;
    flag_hold[BIT_LINE0] = line0_lvl_mode; // R15
    flag_hold[BIT_LINE1] = line1_lvl_mode; // R15
    ack_clr = 8'h00;
    if (vector_ack) begin
      case (irq_vector_r)
        VEC_LINE0: ack_clr[BIT_LINE0] = 1'b1;
        VEC_LINE1: ack_clr[BIT_LINE1] = 1'b1;
        VEC_LINE2: ack_clr[BIT_LINE2] = 1'b1;
        default: ack_clr = 8'h00;
      endcase
    end
  end

  assign flag_clr = ack_clr | (wr_flags ? (wdat & LINE_MASK) : 8'h00); // R14
  // a new trigger wins over a clear in the same cycle
  assign ext_irq_flags_nxt =
    ((ext_irq_flags_r & ~flag_clr) | flag_set) & ~flag_hold & LINE_MASK;

  // ---------------- requests and priority ----------------
  assign req0 = global_en_r & en0 &
                (line0_lvl_mode ? low0 : ext_irq_flags_r[BIT_LINE0]); // R1 R13
  assign req1 = global_en_r & en1 &
                (line1_lvl_mode ? low1 : ext_irq_flags_r[BIT_LINE1]); // R13
  assign req2 = global_en_r & en2 & ext_irq_flags_r[BIT_LINE2]; // R13

  assign vec_nxt = req0 ? VEC_LINE0 : // R11 R19
                   req1 ? VEC_LINE1 :
                   req2 ? VEC_LINE2 : VEC_NONE;

  // ---------------- event status, mask and wake ----------------
  always_comb begin
    evt_set = 8'h00;
    evt_set[BIT_LINE0] = trig0;
    evt_set[BIT_LINE1] = trig1;
    evt_set[BIT_LINE2] = trig2;
  end

  assign evt_clr = (rd_now && rd_idx == IDX_EVT_STATUS) ? evt_status_r : 8'h00;
  assign evt_status_nxt = (evt_status_r & ~evt_clr) | evt_set;

  assign wake_low = {line1_lvl_mode & en1 & low1, line0_lvl_mode & en0 & low0};

  wake_qual #(
    .TICK_CYC(WAKE_TICK_CYC),
    .SAMPLES(WAKE_SAMPLES),
    .LINES(2)
  ) u_wake ( // R18
    .hclk(hclk),
    .hresetn(hresetn),
    .low(wake_low),
    .wake(wake_lvl)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_irq_flags_r <= RST_BYTE;
      evt_status_r <= RST_BYTE;
      irq_req_r <= 1'b0;
      irq_vector_r <= VEC_NONE;
      irq_r <= 1'b0;
      wake_req_r <= 1'b0;
    end else begin
      ext_irq_flags_r <= ext_irq_flags_nxt; // R14
      evt_status_r <= evt_status_nxt;
      irq_req_r <= req0 | req1 | req2; // R13
      irq_vector_r <= vec_nxt; // R19
      irq_r <= |(evt_status_nxt & evt_mask_r);
      wake_req_r <= wake_lvl | (trig2 & en2); // R7
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign irq_req = irq_req_r;
  assign irq_vector = irq_vector_r;
  assign irq = irq_r;
  assign wake_req = wake_req_r;

endmodule : ext_irq_unit
`default_nettype wire

// ### logic/ext_irq_pkg.sv
/*
  Constants for the external pin interrupt unit: register byte offsets,
  field positions, sense and vector encodings, timing constants and the
  bus state type.
  Assumes a 200 MHz hclk and a 32-bit AHB-Lite register bus.
*/
package ext_irq_pkg;

  // clock and timing
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned WDT_PERIOD_NS = 1000;
  localparam int unsigned WDT_CYC = (WDT_PERIOD_NS * CLK_MHZ) / 1000;
  localparam int unsigned WAKE_SAMPLES = 2;
  localparam int unsigned T_INT_NS = 50;
  localparam int unsigned T_INT_CYC = (T_INT_NS * CLK_MHZ) / 1000;

  // register byte offsets
  localparam logic [31:0] OFS_MCU_CTRL = 32'h0000_0000;
  localparam logic [31:0] OFS_MCU_CTRL_STATUS = 32'h0000_0004;
  localparam logic [31:0] OFS_EXT_IRQ_ENABLE = 32'h0000_0008;
  localparam logic [31:0] OFS_EXT_IRQ_FLAGS = 32'h0000_000C;
  localparam logic [31:0] OFS_CPU_STATUS_WORD = 32'h0000_0010;
  localparam logic [31:0] OFS_EVT_STATUS = 32'h0000_0014;
  localparam logic [31:0] OFS_EVT_MASK = 32'h0000_0018;
  localparam logic [31:0] OFS_PIN_STATE = 32'h0000_001C;

  // decoded register index
  localparam logic [3:0] IDX_NONE = 4'h0;
  localparam logic [3:0] IDX_MCU_CTRL = 4'h1;
  localparam logic [3:0] IDX_MCU_CTRL_STATUS = 4'h2;
  localparam logic [3:0] IDX_EXT_IRQ_ENABLE = 4'h3;
  localparam logic [3:0] IDX_EXT_IRQ_FLAGS = 4'h4;
  localparam logic [3:0] IDX_CPU_STATUS_WORD = 4'h5;
  localparam logic [3:0] IDX_EVT_STATUS = 4'h6;
  localparam logic [3:0] IDX_EVT_MASK = 4'h7;
  localparam logic [3:0] IDX_PIN_STATE = 4'h8;

  // field positions
  localparam int unsigned BIT_LINE1 = 7;
  localparam int unsigned BIT_LINE0 = 6;
  localparam int unsigned BIT_LINE2 = 5;
  localparam int unsigned BIT_GLOBAL_EN = 7;
  localparam int unsigned BIT_LINE2_EDGE = 6;
  localparam int unsigned POS_LINE0_SENSE = 0;
  localparam int unsigned POS_LINE1_SENSE = 2;
  localparam logic [7:0] LINE_MASK = 8'hE0;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // sense control codes
  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_ANY = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;

  // vector codes presented to the cpu
  localparam logic [1:0] VEC_NONE = 2'h0;
  localparam logic [1:0] VEC_LINE0 = 2'h1;
  localparam logic [1:0] VEC_LINE1 = 2'h2;
  localparam logic [1:0] VEC_LINE2 = 2'h3;

  // bus constants
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_RDWAIT = 2'b01
  } bus_state_e;

endpackage : ext_irq_pkg

// ### logic/line_sense.sv
/*
  One interrupt line: samples the pin once per clock and turns the sense
  code into a one-cycle trigger pulse.
  Assumes the pin is synchronous to hclk.
*/
`timescale 1ns/1ps
`default_nettype none
module line_sense
  import ext_irq_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin,
  input wire logic [1:0] sense,
  input wire logic clk_run,
  output logic trig,
  output logic level
);
  logic pin_r;
  logic prev_r;
  logic rise;
  logic fall;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_r <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      pin_r <= pin;
      prev_r <= pin_r;
    end
  end

  assign rise = pin_r & ~prev_r;
  assign fall = prev_r & ~pin_r;
  assign level = pin_r;
  // low sense reports the onset of the low level
  assign trig = clk_run & ((sense == SENSE_ANY) ? (rise | fall) :
                (sense == SENSE_RISE) ? rise : fall);

endmodule : line_sense
`default_nettype wire

// ### logic/wake_qual.sv
/*
  Wake-up qualifier for level-sensed lines: a divider makes the slow
  sampling tick and a low level must be seen on consecutive ticks.
  Assumes inputs are already gated by enable and level sense.
*/
`timescale 1ns/1ps
`default_nettype none
module wake_qual
  import ext_irq_pkg::*;
#(
  parameter int unsigned TICK_CYC = WDT_CYC,
  parameter int unsigned SAMPLES = WAKE_SAMPLES,
  parameter int unsigned LINES = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [LINES-1:0] low,
  output logic wake
);
  localparam int unsigned DW = $clog2(TICK_CYC + 1);
  localparam int unsigned SW = $clog2(SAMPLES + 1);
  logic [DW-1:0] div_r;
  logic tick;
  logic [LINES-1:0] hit;

  if (TICK_CYC < 2 || SAMPLES < 1) begin : g_chk
    $error("wake_qual: bad tick or sample count");
  end

  assign tick = (div_r == DW'(TICK_CYC - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) div_r <= '0;
    else div_r <= tick ? '0 : div_r + 1'b1;
  end

  for (genvar i = 0; i < LINES; i++) begin : g_line
    logic [SW-1:0] cnt_r;
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) cnt_r <= '0;
      else if (!low[i]) cnt_r <= '0;
      else if (tick && cnt_r != SW'(SAMPLES)) cnt_r <= cnt_r + 1'b1;
    end
    // the closing sample must itself see the low level, not only the earlier ones
    assign hit[i] = tick && low[i] && (cnt_r == SW'(SAMPLES - 1)); // R18
  end

  assign wake = |hit;

endmodule : wake_qual
`default_nettype wire

// ### tb/pin_board.sv
/*
  Board pin model: drives the three interrupt pins just after the clock edge.
  Assumes the bench sets want; slow adds one cycle of lag.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_board (
  input wire logic hclk,
  input wire logic slow,
  input wire logic [2:0] want,
  output logic [2:0] pins
);
  logic [2:0] lag_r;
  initial lag_r = 3'h7;
  initial pins = 3'h7;
  always @(posedge hclk) begin
    lag_r <= want;
    pins <= slow ? lag_r : want;
  end
endmodule : pin_board
`default_nettype wire

// ### tb/ext_irq_props.sv
/*
  Port assertions for ext_irq_unit, bound to every instance.
  Assumes word writes take effect at the data phase edge.
*/
`timescale 1ns/1ps
`default_nettype none
module ext_irq_props
  import ext_irq_pkg::*;
#(
  parameter int unsigned WAKE_TICK_CYC = WDT_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic ext_irq_line_zero,
  input wire logic ext_irq_line_one,
  input wire logic ext_irq_line_two,
  input wire logic io_clk_run,
  input wire logic sleep_deep,
  input wire logic vector_ack,
  input wire logic irq_req,
  input wire logic [1:0] irq_vector,
  input wire logic irq,
  input wire logic wake_req
);
  logic wr_q;
  logic [31:0] a_q;
  logic [7:0] en_sh;
  logic [7:0] gie_sh;
  wire rd_take = hsel && hready && htrans[1] && !hwrite;
  wire wr_take = hsel && hready && htrans[1] && hwrite && hsize == HSIZE_WORD;
  // shadow of the enables, updated at the same edge as the unit's registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      a_q <= 32'h0;
      en_sh <= 8'h00;
      gie_sh <= 8'h00;
    end else if (hready) begin
      wr_q <= wr_take;
      a_q <= haddr;
      if (wr_q && a_q == OFS_EXT_IRQ_ENABLE) en_sh <= hwdata[7:0];
      if (wr_q && a_q == OFS_CPU_STATUS_WORD) gie_sh <= hwdata[7:0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_resp_okay: assert property (hresp == HRESP_OKAY) else $error("hresp not okay");
  chk_rdata_upper: assert property (hrdata[31:8] == 24'h0) else $error("hrdata upper set");
  chk_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  chk_write_nowait: assert property (wr_take |=> hreadyout) else $error("write stalled");
  chk_vec_pair:
    assert property (irq_req == (irq_vector != VEC_NONE)) else $error("vector without req");
  chk_req_gated:
    assert property (irq_req |-> $past(gie_sh[BIT_GLOBAL_EN] && |(en_sh & LINE_MASK)))
    else $error("request while disabled");
  chk_line0_en:
    assert property (irq_vector == VEC_LINE0 |-> $past(en_sh[BIT_LINE0]))
    else $error("line zero vector while disabled");
  chk_line2_en:
    assert property (irq_vector == VEC_LINE2 |-> $past(en_sh[BIT_LINE2]))
    else $error("line two vector while disabled");
  chk_wake_pulse: assert property (wake_req |=> !wake_req) else $error("wake not a pulse");
  cov_read: cover property (rd_take ##2 hreadyout);
  cov_req: cover property ($rose(irq_req));
  cov_wake: cover property (wake_req);
  cov_irq: cover property ($rose(irq));
endmodule : ext_irq_props
bind ext_irq_unit ext_irq_props #(.WAKE_TICK_CYC(WAKE_TICK_CYC)) i_ext_irq_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .ext_irq_line_zero(ext_irq_line_zero),
  .ext_irq_line_one(ext_irq_line_one), .ext_irq_line_two(ext_irq_line_two),
  .io_clk_run(io_clk_run), .sleep_deep(sleep_deep), .vector_ack(vector_ack),
  .irq_req(irq_req), .irq_vector(irq_vector), .irq(irq), .wake_req(wake_req)
);
`default_nettype wire

// ### tb/testbench.sv
/*
  Self-checking bench for ext_irq_unit: AHB-Lite tasks, a board pin model,
  a table of line zero sense cases, then priority, event, sleep and reset tests.
  Assumes the package, unit, pin model and checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ext_irq_pkg::*;
  typedef struct packed {logic [1:0] sense; logic p0; logic p1; logic flag; logic req;} row_s;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, slow;
  logic io_clk_run, sleep_deep, vector_ack, irq_req, irq, wake_req;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, irq_vector;
  logic [2:0] hsize, want, pins;
  logic [7:0] rv;
  int err_count, check_count, n;
  row_s rows [7] = '{6'h09, 6'h1B, 6'h17, 6'h2B, 6'h24, 6'h37, 6'h38};
  ext_irq_unit #(.WAKE_TICK_CYC(4)) i_ext_irq_unit (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ext_irq_line_zero(pins[0]),
    .ext_irq_line_one(pins[1]), .ext_irq_line_two(pins[2]), .io_clk_run(io_clk_run),
    .sleep_deep(sleep_deep), .vector_ack(vector_ack), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq(irq), .wake_req(wake_req)
  );
  pin_board i_pin_board (.hclk(hclk), .slow(slow), .want(want), .pins(pins));
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge hclk);
    #1;
  endtask : cyc
  // waits for a rising edge with hready high; read data is taken at that edge
  task automatic ph();
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rv = hrdata[7:0];
  endtask : ph
  task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(posedge hclk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    ph();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    ph();
  endtask : xfer
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // pins held 60 ns, beyond the minimum pulse width
  task automatic pins_to(input logic [2:0] v);
    @(posedge hclk);
    want <= v;
    cyc(12);
  endtask : pins_to
  task automatic ack();
    @(posedge hclk);
    vector_ack <= 1'b1;
    @(posedge hclk);
    vector_ack <= 1'b0;
    cyc(3);
  endtask : ack
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    #100000;
    err_count++;
    print_verdict();
  end
  initial begin
    {hresetn, hwrite, slow, sleep_deep, vector_ack} = 5'h00;
    {hsel, io_clk_run} = 2'h3;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = HSIZE_WORD;
    want = 3'h7;
    err_count = 0;
    check_count = 0;
    cyc(2);
    hresetn <= 1'b1;
    xfer(1'b1, 32'h40, 8'hFF);
    for (n = 0; n < 8; n++) begin
      xfer(1'b0, n < 7 ? 32'(n * 4) : 32'h40, 8'h00);
      chk("reset value", rv, 8'h00);
    end
    xfer(1'b0, OFS_PIN_STATE, 8'h00);
    chk("pin state", rv, 8'hE0);
    xfer(1'b1, OFS_EXT_IRQ_ENABLE, LINE_MASK);
    xfer(1'b1, OFS_CPU_STATUS_WORD, 8'h80);
    foreach (rows[k]) begin
      pins_to({2'h3, rows[k].p0});
      xfer(1'b1, OFS_MCU_CTRL, {6'h00, rows[k].sense});
      xfer(1'b1, OFS_EXT_IRQ_FLAGS, LINE_MASK);
      pins_to({2'h3, rows[k].p1});
      chk("table req", {7'h00, irq_req}, {7'h00, rows[k].req});
      chk("table vector", {6'h00, irq_vector}, rows[k].req ? 8'h01 : 8'h00);
      xfer(1'b0, OFS_EXT_IRQ_FLAGS, 8'h00);
      chk("table flag", rv, {1'b0, rows[k].flag, 6'h00});
    end
    slow <= 1'b1;
    xfer(1'b1, OFS_MCU_CTRL, 8'h0A);
    pins_to(3'h7);
    xfer(1'b1, OFS_EXT_IRQ_FLAGS, LINE_MASK);
    pins_to(3'h0);
    for (n = 1; n < 4; n++) begin
      chk("priority vector", {6'h00, irq_vector}, 8'(n));
      ack();
    end
    chk("vector after entries", {7'h00, irq_req}, 8'h00);
    xfer(1'b1, OFS_CPU_STATUS_WORD, 8'h00);
    pins_to(3'h7);
    xfer(1'b1, OFS_EXT_IRQ_FLAGS, LINE_MASK);
    pins_to(3'h6);
    chk("global enable off", {7'h00, irq_req}, 8'h00);
    xfer(1'b1, OFS_EXT_IRQ_FLAGS, 8'h00);
    xfer(1'b1, OFS_CPU_STATUS_WORD, 8'h80);
    cyc(2);
    chk("zero write kept flag", {6'h00, irq_vector}, {6'h00, VEC_LINE0});
    ack();
    pins_to(3'h2);
    xfer(1'b1, OFS_EXT_IRQ_ENABLE, 8'hC0);
    xfer(1'b1, OFS_MCU_CTRL_STATUS, 8'h40);
    xfer(1'b1, OFS_EXT_IRQ_FLAGS, LINE_MASK);
    xfer(1'b1, OFS_EXT_IRQ_ENABLE, LINE_MASK);
    pins_to(3'h6);
    chk("line two vector", {6'h00, irq_vector}, {6'h00, VEC_LINE2});
    xfer(1'b0, OFS_EXT_IRQ_FLAGS, 8'h00);
    chk("rising line two", rv, 8'h20);
    ack();
    xfer(1'b1, OFS_EVT_MASK, 8'h40);
    pins_to(3'h3);
    xfer(1'b0, OFS_EVT_STATUS, 8'h00);
    pins_to(3'h7);
    chk("masked event", {7'h00, irq}, 8'h00);
    pins_to(3'h6);
    chk("unmasked event", {7'h00, irq}, 8'h01);
    xfer(1'b0, OFS_EVT_STATUS, 8'h00);
    chk("sticky events", rv, 8'h60);
    cyc(2);
    chk("read clears", {7'h00, irq}, 8'h00);
    io_clk_run <= 1'b0;
    xfer(1'b1, OFS_MCU_CTRL, 8'h08);
    xfer(1'b1, OFS_MCU_CTRL_STATUS, 8'h00);
    xfer(1'b1, OFS_EXT_IRQ_ENABLE, 8'hC0);
    pins_to(3'h7);
    xfer(1'b1, OFS_EXT_IRQ_FLAGS, LINE_MASK);
    @(posedge hclk);
    sleep_deep <= 1'b1;
    want <= 3'h4;
    for (n = 0; n < 60 && wake_req !== 1'b1; n++) @(negedge hclk);
    chk("level wake", {7'h00, wake_req}, 8'h01);
    xfer(1'b0, OFS_EXT_IRQ_FLAGS, 8'h00);
    chk("sleep flags", rv, 8'h20);
    {sleep_deep, hresetn} <= 2'h0;
    cyc(2);
    hresetn <= 1'b1;
    xfer(1'b0, OFS_EXT_IRQ_ENABLE, 8'h00);
    chk("second reset", rv, 8'h00);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
